/* core/tam_params.svh */
// constants of the t1 receive alarm and status monitor
// assumes: included by bare name from design files
// Function
// - flag alignment change after a resync
// - flag eight and sixteen zero runs
// - flag receive store overfill frame drop
// - flag receive store underrun frame repeat
// - flag receive slip on repeat or drop
// - flag two framing errors in six
// - flag zero substitution codeword, mode regardless
// - flag each framing bit error
// - report received level as two bit code
// - flag transmit store overfill frame drop
// - flag transmit store underrun frame repeat
// - flag transmit slip on repeat or drop
// - flag jitter fifo within four of limit
// - flag receive and transmit density violations
// - flag loop up and loop down codes
// - flag transmit clock loss, drive alarm pin
// - red alarm on 192 zeros, clear 14/112
// - hold sync loss while framer unsynchronised
// - blue alarm from zeros per 3 ms
// - bit two yellow, 254 of 256 channels
// - twelfth bit yellow, two in row
// - data link yellow, sixteen patterns, clear 14
// - status bits latch until mask write
// - mask write loads copy, clears latch
// - first status bits gated onto interrupt
`ifndef TAM_PARAMS_SVH
`define TAM_PARAMS_SVH
`define TAM_ADDR_LAS 8'h20
`define TAM_ADDR_REI 8'h22
`define TAM_ADDR_LSD 8'h31
`define TAM_RX_CLK_NS 125
`define TAM_TX_CLOCK_IN_LOSS_NS 5200
`define TAM_TX_CLOCK_IN_LOSS_CYC (`TAM_TX_CLOCK_IN_LOSS_NS / `TAM_RX_CLK_NS)
`define TAM_BLUE_WIN_US 3000
`define TAM_BLUE_WIN_CYC (`TAM_BLUE_WIN_US * 1000 / `TAM_RX_CLK_NS)
`define TAM_LOOP_INT_US 48000
`define TAM_LOOP_INT_CYC (`TAM_LOOP_INT_US * 1000 / `TAM_RX_CLK_NS)
`define TAM_EIGHT_ZEROS 8'd8
`define TAM_SIXTEEN_ZEROS 8'd16
`define TAM_RED_SET_ZEROS 8'd192
`define TAM_RED_CLR_ONES 4'd14
`define TAM_RED_CLR_WIN 7'd112
`define TAM_BLUE_MAX_ZEROS 3'd5
`define TAM_BLUE_SAT 3'd6
`define TAM_YEL_LAST_CH 8'hff
`define TAM_YEL_MIN_ZERO 9'd254
`define TAM_ESF_CLR_MAX 14
`define TAM_SEF_ERRS 2
`define TAM_DENS_MAX_ZEROS 5'd15
`define TAM_JIT_MARGIN 8'd4
`define TAM_JIT_SMALL 8'd32
`define TAM_JIT_LARGE 8'd128
`define TAM_B8ZS_V 8'h11
`define TAM_B8ZS_B 8'h0a
`define TAM_LUP_PAT 5'h01
`define TAM_LDN_PAT 5'h03
`endif

/* core/tam_pkg.sv */
// types of the t1 receive alarm and status monitor
// assumes: compiled before the monitor
package tam_pkg;
	// one bit per event that crosses as a toggle
	typedef struct packed {
		logic slip, alignment_change_flag, z8, z16, rx_store_full_flag, rx_store_empty_flag, severe_framing_flag, b8zs, fbe, tx_store_full_flag, tx_store_empty_flag, tx_slip_flag, rx_density_violation, tx_density_violation;
	} tam_ev_s;
	// levels that cross through a three stage synchroniser
	typedef struct packed {
		logic loop_up_flag, loop_down_flag, tx_clock_loss_flag, blue, yel, red, los, jitter_limit_flag;
		logic [1:0] lvl;
	} tam_lv_s;
	// framer strobes on the receive clock
	typedef struct packed {
		logic sync_ok, resync_done, align_changed, fbit_en, fbit_err;
		logic bit2_en, bit2, f12_en, f12, fdl_en, fdl_match;
	} tam_frm_s;
	// elastic store slip events on the receive clock
	typedef struct packed {
		logic rx_full, rx_empty, tx_full, tx_empty;
	} tam_store_s;
	// receive clock domain state
	typedef struct packed {
		logic rst_s1, rst_s2, tck_s1, tck_s2, tck_s3;
		logic [5:0] tcnt;
		logic [7:0] zrun;
		logic rarm;
		logic [6:0] rwin;
		logic [3:0] rones;
		logic [15:0] bwin;
		logic [2:0] bzero;
		logic [7:0] ych;
		logic [8:0] yzero;
		logic f12_prev;
		logic [15:0] esf_hist;
		logic [5:0] fhist;
		logic [7:0] pos_w, neg_w;
		logic last_pol;
		logic [4:0] dz_rx, dz_tx, lsr;
		logic [19:0] lu_cnt, ld_cnt;
		tam_lv_s lv;
		tam_ev_s tog;
	} tam_rx_s;
	// host clock domain state
	typedef struct packed {
		tam_ev_s ev_s1, ev_s2, ev_s3;
		tam_lv_s lv_s1, lv_s2, lv_s3, lv_q;
		logic [2:0][7:0] latch, copy;
		logic [7:0] rdata;
		logic irq, alarm;
	} tam_ck_s;
endpackage

/* core/tam_monitor.sv */
// receive alarm and status monitor with three latched status registers
// assumes: framer, stores and line interface give strobes on i_rx_clk,
// the host port is synchronous to i_clk, i_rx_clk runs free
`timescale 1ns/1ps
`include "tam_params.svh"

module tam_monitor #(
	parameter int BLUE_WIN_CYC = `TAM_BLUE_WIN_CYC,
	parameter int LOOP_INT_CYC = `TAM_LOOP_INT_CYC,
	parameter logic [4:0] LDN_PAT = `TAM_LDN_PAT
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_rx_clk,
	input wire logic i_rx_positive_rail,
	input wire logic i_rx_negative_rail,
	input wire logic i_rx_data,
	input wire logic i_tx_data,
	input wire logic i_tx_bit_en,
	input wire logic i_tx_clock_in,
	input wire tam_pkg::tam_frm_s i_framer,
	input wire tam_pkg::tam_store_s i_store,
	input wire logic [7:0] i_jit_fill,
	input wire logic i_jit_deep,
	input wire logic [1:0] i_rx_level,
	input wire logic i_esf_mode,
	input wire logic i_yellow_mode_select,
	input wire logic i_clock_loss_output_enable,
	input wire logic [7:0] i_irq_mask_first,
	input wire logic i_cs,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_irq_out_first,
	output logic o_tx_clock_alarm
);

	////////////////////////////////////////////////////////////////////
	// constants derived at the receive clock rate

	localparam logic [5:0] TCK_LOSS = 6'(`TAM_TX_CLOCK_IN_LOSS_CYC); // cycles without edge
	localparam logic [15:0] BLUE_LAST = 16'(BLUE_WIN_CYC - 1); // last cycle of window
	localparam logic [19:0] LOOP_N = 20'(LOOP_INT_CYC); // integration length

	// true when v is any rotation of pattern p
	function automatic logic is_rot(input logic [4:0] v, input logic [4:0] p);
		logic hit;
		logic [9:0] vv;
		hit = 1'b0;
		vv = {v, v};
		for (int k = 0; k < 5; k++) begin
			hit = hit | (vv[k +: 5] == p);
		end
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////
	// receive clock domain

	tam_pkg::tam_rx_s rx; // registered state
	tam_pkg::tam_rx_s next_rx; // next state
	tam_pkg::tam_ev_s ev; // events of this bit
	logic zero; // no pulse on either rail
	logic [2:0] bz; // blue zeros including this bit
	logic [8:0] yz; // yellow zeros including this channel
	logic [15:0] hist; // data link match history
	logic [7:0] jit_lim; // jitter fifo limit
	logic lu_hit; // bit continues loop up code
	logic ld_hit; // bit continues loop down code

	// next state of the line watchers
	always_comb begin
		next_rx = rx;
		ev = '0;
		bz = rx.bzero;
		yz = rx.yzero;
		hist = rx.esf_hist;
		zero = !(i_rx_positive_rail | i_rx_negative_rail);
		jit_lim = i_jit_deep ? `TAM_JIT_LARGE : `TAM_JIT_SMALL;

		// transmit clock watched through three flops
		next_rx.tck_s1 = i_tx_clock_in;
		next_rx.tck_s2 = rx.tck_s1;
		next_rx.tck_s3 = rx.tck_s2;
		if (rx.tck_s2 != rx.tck_s3) begin
			next_rx.tcnt = 6'd0; // edge seen, restart
		end else if (rx.tcnt != TCK_LOSS) begin
			next_rx.tcnt = rx.tcnt + 6'd1;
		end
		next_rx.lv.tx_clock_loss_flag = (next_rx.tcnt == TCK_LOSS);

		// zero run on the rails, saturating at the red threshold
		if (!zero) begin
			next_rx.zrun = 8'd0;
		end else if (rx.zrun != `TAM_RED_SET_ZEROS) begin
			next_rx.zrun = rx.zrun + 8'd1;
		end
		ev.z8 = zero && (next_rx.zrun == `TAM_EIGHT_ZEROS);
		ev.z16 = zero && (next_rx.zrun == `TAM_SIXTEEN_ZEROS);

		// red alarm: set on long zero run, clear on ones density
		if (!rx.lv.red) begin
			next_rx.rarm = 1'b0;
			if (next_rx.zrun == `TAM_RED_SET_ZEROS) begin
				next_rx.lv.red = 1'b1;
			end
		end else if (!rx.rarm) begin
			// window opens on the first one
			if (!zero) begin
				next_rx.rarm = 1'b1;
				next_rx.rwin = 7'd1;
				next_rx.rones = 4'd1;
			end
		end else begin
			next_rx.rwin = rx.rwin + 7'd1;
			if (!zero) begin
				next_rx.rones = rx.rones + 4'd1;
			end
			if (next_rx.rones == `TAM_RED_CLR_ONES) begin
				next_rx.lv.red = 1'b0;
				next_rx.rarm = 1'b0;
			end else if (next_rx.rwin == `TAM_RED_CLR_WIN) begin
				next_rx.rarm = 1'b0; // too sparse, wait for next one
			end
		end

		// blue alarm: zeros counted over a fixed window
		if (zero && (rx.bzero != `TAM_BLUE_SAT)) begin
			bz = rx.bzero + 3'd1;
		end
		if (rx.bwin == BLUE_LAST) begin
			next_rx.lv.blue = (bz <= `TAM_BLUE_MAX_ZEROS);
			next_rx.bwin = 16'd0;
			next_rx.bzero = 3'd0;
		end else begin
			next_rx.bwin = rx.bwin + 16'd1;
			next_rx.bzero = bz;
		end

		// yellow alarm in the selected mode
		if (i_esf_mode) begin
			// data link pattern matches, last sixteen kept
			if (i_framer.fdl_en) begin
				hist = {rx.esf_hist[14:0], i_framer.fdl_match};
				next_rx.esf_hist = hist;
				if (&hist) begin
					next_rx.lv.yel = 1'b1;
				end else if ($countones(hist) <= `TAM_ESF_CLR_MAX) begin
					next_rx.lv.yel = 1'b0;
				end
			end
		end else if (i_yellow_mode_select) begin
			// twelfth framing bit, two alike in a row decide
			if (i_framer.f12_en) begin
				if (i_framer.f12 == rx.f12_prev) begin
					next_rx.lv.yel = i_framer.f12;
				end
				next_rx.f12_prev = i_framer.f12;
			end
		end else begin
			// bit two of each channel over blocks of 256
			if (i_framer.bit2_en) begin
				yz = rx.yzero + {8'd0, !i_framer.bit2};
				if (rx.ych == `TAM_YEL_LAST_CH) begin
					next_rx.lv.yel = (yz >= `TAM_YEL_MIN_ZERO);
					next_rx.ych = 8'd0;
					next_rx.yzero = 9'd0;
				end else begin
					next_rx.ych = rx.ych + 8'd1;
					next_rx.yzero = yz;
				end
			end
		end

		// framing bit errors and their six bit history
		if (i_framer.fbit_en) begin
			next_rx.fhist = {rx.fhist[4:0], i_framer.fbit_err};
			ev.fbe = i_framer.fbit_err;
			ev.severe_framing_flag = i_framer.fbit_err && ($countones(next_rx.fhist) >= `TAM_SEF_ERRS);
		end

		// substitution codeword on the rails, decoding mode ignored
		next_rx.pos_w = {rx.pos_w[6:0], i_rx_positive_rail};
		next_rx.neg_w = {rx.neg_w[6:0], i_rx_negative_rail};
		if (rx.pos_w[7]) begin
			next_rx.last_pol = 1'b1; // pulse leaving window was positive
		end else if (rx.neg_w[7]) begin
			next_rx.last_pol = 1'b0;
		end
		if (next_rx.last_pol) begin
			ev.b8zs = (next_rx.pos_w == `TAM_B8ZS_V) && (next_rx.neg_w == `TAM_B8ZS_B);
		end else begin
			ev.b8zs = (next_rx.neg_w == `TAM_B8ZS_V) && (next_rx.pos_w == `TAM_B8ZS_B);
		end

		// ones density on the receive data stream
		if (i_rx_data) begin
			next_rx.dz_rx = 5'd0;
		end else if (rx.dz_rx != `TAM_DENS_MAX_ZEROS + 5'd1) begin
			next_rx.dz_rx = rx.dz_rx + 5'd1;
		end
		ev.rx_density_violation = !i_rx_data && (rx.dz_rx == `TAM_DENS_MAX_ZEROS);
		// ones density on the transmit data stream
		if (i_tx_bit_en) begin
			if (i_tx_data) begin
				next_rx.dz_tx = 5'd0;
			end else if (rx.dz_tx != `TAM_DENS_MAX_ZEROS + 5'd1) begin
				next_rx.dz_tx = rx.dz_tx + 5'd1;
			end
			ev.tx_density_violation = !i_tx_data && (rx.dz_tx == `TAM_DENS_MAX_ZEROS);
		end

		// loop codes: period five repetition of a known pattern
		next_rx.lsr = {rx.lsr[3:0], i_rx_data};
		lu_hit = (i_rx_data == rx.lsr[4]) && is_rot(next_rx.lsr, `TAM_LUP_PAT);
		ld_hit = (i_rx_data == rx.lsr[4]) && is_rot(next_rx.lsr, LDN_PAT);
		if (!lu_hit) begin
			next_rx.lu_cnt = 20'd0;
		end else if (rx.lu_cnt != LOOP_N) begin
			next_rx.lu_cnt = rx.lu_cnt + 20'd1;
		end
		if (!ld_hit) begin
			next_rx.ld_cnt = 20'd0;
		end else if (rx.ld_cnt != LOOP_N) begin
			next_rx.ld_cnt = rx.ld_cnt + 20'd1;
		end
		next_rx.lv.loop_up_flag = (next_rx.lu_cnt == LOOP_N);
		next_rx.lv.loop_down_flag = (next_rx.ld_cnt == LOOP_N);

		// plain levels sampled every bit
		next_rx.lv.los = !i_framer.sync_ok;
		next_rx.lv.jitter_limit_flag = (i_jit_fill >= jit_lim - `TAM_JIT_MARGIN);
		next_rx.lv.lvl = i_rx_level;

		// events handed in by framer and stores
		ev.alignment_change_flag = i_framer.resync_done && i_framer.align_changed;
		ev.rx_store_full_flag = i_store.rx_full;
		ev.rx_store_empty_flag = i_store.rx_empty;
		ev.slip = i_store.rx_full | i_store.rx_empty;
		ev.tx_store_full_flag = i_store.tx_full;
		ev.tx_store_empty_flag = i_store.tx_empty;
		ev.tx_slip_flag = i_store.tx_full | i_store.tx_empty;
		next_rx.tog = tam_pkg::tam_ev_s'(rx.tog ^ ev); // one toggle per event

		// synchronous reset taken over from the host clock
		if (rx.rst_s2) begin
			next_rx = '0;
		end
		next_rx.rst_s1 = i_srst;
		next_rx.rst_s2 = rx.rst_s1;
	end

	// receive state register
	always_ff @(posedge i_rx_clk) begin
		rx <= next_rx;
	end

	////////////////////////////////////////////////////////////////////
	// host clock domain: crossings, latches and register port

	tam_pkg::tam_ck_s ck; // registered state
	tam_pkg::tam_ck_s next_ck; // next state
	tam_pkg::tam_ev_s cev; // event pulses after crossing
	logic [2:0][7:0] cond; // set terms of the three registers
	logic [2:0][7:0] wm; // write masks
	logic [1:0] sel; // addressed register
	logic hit; // address maps to a register

	// address decode of the parallel port
	always_comb begin
		sel = 2'd0;
		hit = 1'b0;
		if (i_addr == `TAM_ADDR_LAS) begin
			sel = 2'd0;
			hit = 1'b1;
		end else if (i_addr == `TAM_ADDR_REI) begin
			sel = 2'd1;
			hit = 1'b1;
		end else if (i_addr == `TAM_ADDR_LSD) begin
			sel = 2'd2;
			hit = 1'b1;
		end
	end

	// next state of crossings, latches and read port
	always_comb begin
		next_ck = ck;
		next_ck.ev_s1 = rx.tog;
		next_ck.ev_s2 = ck.ev_s1;
		next_ck.ev_s3 = ck.ev_s2;
		next_ck.lv_s1 = rx.lv;
		next_ck.lv_s2 = ck.lv_s1;
		next_ck.lv_s3 = ck.lv_s2;
		// a level counts once the last two stages agree
		if (ck.lv_s2 == ck.lv_s3) begin
			next_ck.lv_q = ck.lv_s3;
		end
		cev = tam_pkg::tam_ev_s'(ck.ev_s2 ^ ck.ev_s3);
		cond[0] = {ck.lv_q.loop_up_flag, ck.lv_q.loop_down_flag, ck.lv_q.tx_clock_loss_flag, cev.slip,
			ck.lv_q.blue, ck.lv_q.yel, ck.lv_q.red, ck.lv_q.los};
		cond[1] = {cev.alignment_change_flag, cev.z8, cev.z16, cev.rx_store_full_flag, cev.rx_store_empty_flag, cev.severe_framing_flag, cev.b8zs, cev.fbe};
		cond[2] = {ck.lv_q.lvl, cev.tx_store_full_flag, cev.tx_store_empty_flag, cev.tx_slip_flag, ck.lv_q.jitter_limit_flag, cev.rx_density_violation, cev.tx_density_violation};
		// mask write: ones load copy from latch and clear latch
		for (int r = 0; r < 3; r++) begin
			wm[r] = (i_cs && i_wr && hit && (sel == 2'(r))) ? i_wdata : 8'h00;
			next_ck.copy[r] = (ck.copy[r] & ~wm[r]) | (ck.latch[r] & wm[r]);
			next_ck.latch[r] = (ck.latch[r] & ~wm[r]) | cond[r];
		end
		// read returns the copy, unmapped reads give zero
		if (i_cs && i_rd) begin
			next_ck.rdata = hit ? ck.copy[sel] : 8'h00;
		end
		next_ck.irq = |(ck.latch[0] & i_irq_mask_first);
		next_ck.alarm = ck.lv_q.tx_clock_loss_flag && i_clock_loss_output_enable;
		if (i_srst) begin
			next_ck = '0;
		end
	end

	// host state register
	always_ff @(posedge i_clk) begin
		ck <= next_ck;
	end

	assign o_rdata = ck.rdata;
	assign o_irq_out_first = ck.irq;
	assign o_tx_clock_alarm = ck.alarm;

	////////////////////////////////////////////////////////////////////
	// checks on the receive clock

	chk_zero_eight: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(zero && rx.zrun == 8'd7) |=> $changed(rx.tog.z8))
		else $error("eight zero event missed");

	chk_zero_sixteen: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(zero && rx.zrun == 8'd15) |=> $changed(rx.tog.z16))
		else $error("sixteen zero event missed");

	chk_red_set: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(!rx.lv.red && zero && rx.zrun == 8'd191) |=> rx.lv.red)
		else $error("red alarm not set after 192 zeros");

	chk_red_hold: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(rx.lv.red && !rx.rarm) |=> rx.lv.red)
		else $error("red alarm cleared without ones window");

	chk_tx_clock_in_loss: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		rx.lv.tx_clock_loss_flag |-> (rx.tcnt == 6'd41))
		else $error("clock loss flag without full quiet time");

	chk_tx_clock_in_back: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(rx.tck_s2 != rx.tck_s3) |=> !rx.lv.tx_clock_loss_flag)
		else $error("clock loss flag stays after edge");

	chk_severe_frame: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(i_framer.fbit_en && i_framer.fbit_err && ($countones(rx.fhist[4:0]) >= 1))
		|=> $changed(rx.tog.severe_framing_flag))
		else $error("severe framing event missed");

	chk_yel_twelfth: assert property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		(!i_esf_mode && i_yellow_mode_select && i_framer.f12_en && i_framer.f12
		&& rx.f12_prev) |=> rx.lv.yel)
		else $error("twelfth bit yellow not set");

	cov_red_cycle: cover property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		$fell(rx.lv.red));

	cov_clock_loss: cover property (@(posedge i_rx_clk) disable iff (rx.rst_s2)
		$rose(rx.lv.tx_clock_loss_flag));

	////////////////////////////////////////////////////////////////////
	// checks on the host clock

	chk_set_wins: assert property (@(posedge i_clk) disable iff (i_srst)
		(cond[1] != 8'h00) |=> ((ck.latch[1] & $past(cond[1])) == $past(cond[1])))
		else $error("event lost in latch");

	chk_mask_load: assert property (@(posedge i_clk) disable iff (i_srst)
		(wm[1] != 8'h00) |=> ((ck.copy[1] & $past(wm[1])) == ($past(ck.latch[1]) & $past(wm[1]))))
		else $error("masked copy not loaded");

	chk_mask_keep: assert property (@(posedge i_clk) disable iff (i_srst)
		(wm[2] != 8'h00) |=> ((ck.copy[2] & ~$past(wm[2])) == ($past(ck.copy[2]) & ~$past(wm[2]))))
		else $error("unmasked copy bits changed");

	chk_irq_gate: assert property (@(posedge i_clk) disable iff (i_srst)
		1'b1 |=> (o_irq_out_first == |($past(ck.latch[0]) & $past(i_irq_mask_first))))
		else $error("interrupt not gated by mask");

	chk_read_copy: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_cs && i_rd && i_addr == 8'h22) |=> (o_rdata == $past(ck.copy[1])))
		else $error("read data differs from copy");

	cov_write_read: cover property (@(posedge i_clk) disable iff (i_srst)
		(wm[0] != 8'h00) ##1 (i_cs && i_rd && i_addr == 8'h20 && ck.copy[0] != 8'h00));

	cov_irq: cover property (@(posedge i_clk) disable iff (i_srst)
		$rose(o_irq_out_first));

endmodule

/* tb/tam_line_model.sv */
// remote line equipment: bipolar rails, decoded data and the transmit clock
// assumes: i_rx_clk runs free; the bench picks a mark or a space for each bit
`timescale 1ns/1ps

module tam_line_model (
	input wire logic i_rx_clk,
	input wire logic i_send_ones,
	input wire logic i_tx_clock_in_run,
	input wire logic i_send_cw,
	output logic o_pos,
	output logic o_neg,
	output logic o_data,
	output logic o_tx_clock_in
);
	logic pol; // polarity of the last mark sent
	logic [7:0] cw_p, cw_n; // rails of a codeword still to send, oldest on top

	// outputs start quiet
	initial begin
		{o_pos, o_neg, o_data, o_tx_clock_in, pol, cw_p, cw_n} = 21'h000000;
	end

	// alternate mark inversion: a space puts no pulse on either rail; on
	// request the next eight bits carry a substitution codeword instead
	always @(posedge i_rx_clk) begin
		#2;
		if (i_send_cw && (cw_p | cw_n) == 8'h00) begin
			// first violation repeats the polarity of the last mark
			cw_p = pol ? 8'h11 : 8'h0a;
			cw_n = pol ? 8'h0a : 8'h11;
		end
		if ((cw_p | cw_n) != 8'h00) begin
			{o_data, o_pos, o_neg} = {1'b0, cw_p[7], cw_n[7]};
			cw_p = cw_p << 1;
			cw_n = cw_n << 1;
		end else begin
			o_data = i_send_ones;
			o_pos = i_send_ones & ~pol;
			o_neg = i_send_ones & pol;
			if (i_send_ones) begin
				pol = ~pol;
			end
		end
	end

	// transmit clock toggles while running and stands still when stopped
	always begin
		#324;
		if (i_tx_clock_in_run) begin
			o_tx_clock_in = ~o_tx_clock_in;
		end
	end
endmodule

/* tb/testbench.sv */
// self-checking bench of the alarm and status monitor
// assumes: tam_pkg compiled first, line model drives rails and transmit clock
`timescale 1ns/1ps

module testbench;
	logic i_clk, i_srst, i_rx_clk, i_rx_positive_rail, i_rx_negative_rail, i_rx_data;
	logic i_tx_data, i_tx_bit_en, i_tx_clock_in, i_jit_deep, i_esf_mode;
	logic i_yellow_mode_select, i_clock_loss_output_enable, i_cs, i_wr, i_rd;
	tam_pkg::tam_frm_s i_framer; // framer strobes, rx clock
	tam_pkg::tam_store_s i_store; // store slip pulses, rx clock
	logic [7:0] i_jit_fill, i_irq_mask_first, i_addr, i_wdata, o_rdata;
	logic [1:0] i_rx_level;
	logic o_irq_out_first, o_tx_clock_alarm;
	logic line_ones, tx_clock_in_run, line_cw; // line model controls
	localparam logic [4:0] LOOP_DOWN_FLAG = 5'h03; // loop down word given to the design
	logic [31:0] seed; // xorshift state
	logic [23:0] e; // expected {0x20, 0x22, 0x31}
	int mismatches, comparisons, cycles, k;
	int zt[5] = '{7, 8, 16, 191, 192}; // zero run lengths around each threshold

	tam_monitor #(.BLUE_WIN_CYC(64), .LOOP_INT_CYC(20), .LDN_PAT(LOOP_DOWN_FLAG)) u_dut (.*);
	tam_line_model u_line (.i_rx_clk(i_rx_clk), .i_send_ones(line_ones),
		.i_tx_clock_in_run(tx_clock_in_run), .i_send_cw(line_cw), .o_pos(i_rx_positive_rail),
		.o_neg(i_rx_negative_rail), .o_data(i_rx_data), .o_tx_clock_in(i_tx_clock_in));

	////////////////////////////////////////////////////////////////////////////////
	// clocks: host 10 ns, line 125 ns with an unrelated phase
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		i_rx_clk = 1'b0;
		#3.3;
		forever #62.5 i_rx_clk = ~i_rx_clk;
	end
	// hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			stop_test();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one host cycle, strobe held up to the taking edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		{i_cs, i_wr, i_rd, i_addr, i_wdata} = {1'b1, w, ~w, a, d};
		@(posedge i_clk);
		#1;
		{i_cs, i_wr, i_rd} = 3'h0;
	endtask
	// mask write, read, write back the masked value
	task automatic acc(input logic [7:0] a, input logic [7:0] m, output logic [7:0] q);
		bus(1'b1, a, m);
		bus(1'b0, a, 8'h00);
		q = o_rdata & m;
		bus(1'b1, a, q);
	endtask
	task automatic look(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
		logic [7:0] q;
		acc(a, m, q);
		check(q, x);
	endtask
	task automatic clr_all();
		logic [7:0] q;
		acc(8'h20, 8'hff, q);
		acc(8'h22, 8'hff, q);
		acc(8'h31, 8'hff, q);
	endtask
	// let line events cross into the host domain
	task automatic settle();
		repeat (3) @(posedge i_rx_clk);
		repeat (8) @(posedge i_clk);
	endtask
	task automatic pulse(input tam_pkg::tam_frm_s f, input tam_pkg::tam_store_s s);
		@(posedge i_rx_clk);
		#2;
		i_framer = f;
		i_framer.sync_ok = 1'b1;
		i_store = s;
		@(posedge i_rx_clk);
		#2;
		i_framer = '0;
		i_framer.sync_ok = 1'b1;
		i_store = '0;
	endtask
	task automatic fbit(input logic err);
		tam_pkg::tam_frm_s f;
		f = '0;
		f.fbit_en = 1'b1;
		f.fbit_err = err;
		pulse(f, '0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		tam_pkg::tam_frm_s f;
		tam_pkg::tam_store_s s;
		logic [4:0] pat;
		seed = 32'h946b367a;
		{mismatches, comparisons, cycles} = '0;
		{i_cs, i_wr, i_rd, i_addr, i_wdata, i_tx_data, i_tx_bit_en} = '0;
		{i_esf_mode, i_yellow_mode_select, i_jit_deep, i_jit_fill, i_rx_level} = '0;
		i_framer = '0;
		i_framer.sync_ok = 1'b1;
		i_store = '0;
		{line_cw, line_ones, tx_clock_in_run, i_clock_loss_output_enable} = 4'h7;
		i_irq_mask_first = 8'h20;
		// reset held long enough to cover three line clocks
		i_srst = 1'b1;
		repeat (48) @(posedge i_clk);
		#1;
		i_srst = 1'b0;
		// readable copies start at zero; unmapped place reads zero
		bus(1'b0, 8'h20, 8'h00);
		check(o_rdata, 8'h00);
		bus(1'b0, 8'h22, 8'h00);
		check(o_rdata, 8'h00);
		bus(1'b0, 8'h31, 8'h00);
		check(o_rdata, 8'h00);
		look(8'h21, 8'hff, 8'h00);
		// zero runs on either side of each threshold
		foreach (zt[i]) begin
			clr_all();
			@(posedge i_rx_clk);
			#1;
			line_ones = 1'b0;
			repeat (zt[i]) @(posedge i_rx_clk);
			#1;
			line_ones = 1'b1;
			settle();
			look(8'h22, 8'h60, {1'b0, zt[i] >= 8, zt[i] >= 16, 5'h00});
			look(8'h31, 8'h02, {6'h00, zt[i] >= 16, 1'b0});
			look(8'h20, 8'h02, {6'h00, zt[i] >= 192, 1'b0});
			repeat (24) @(posedge i_rx_clk);
		end
		// loop up, then loop down, each sent as 40 bits of its word
		for (int c = 0; c < 2; c++) begin
			pat = c ? LOOP_DOWN_FLAG : 5'h01;
			clr_all();
			for (int i = 0; i < 40; i++) begin
				@(posedge i_rx_clk);
				#1;
				line_ones = pat[4 - i % 5];
			end
			settle();
			look(8'h20, 8'hc0, {c == 0, c == 1, 6'h00});
		end
		line_ones = 1'b1;
		// one substitution codeword among marks, no eight zero run on the rails
		clr_all();
		@(posedge i_rx_clk);
		#1;
		line_cw = 1'b1;
		@(posedge i_rx_clk);
		#1;
		line_cw = 1'b0;
		repeat (8) @(posedge i_rx_clk);
		settle();
		look(8'h22, 8'h42, 8'h02);
		clr_all();
		look(8'h20, 8'h02, 8'h00);
		// random store and framer events
		for (int i = 0; i < 12; i++) begin
			k = int'(rnd() % 32'd6);
			f = '0;
			s = '0;
			case (k)
				0: begin s.rx_full = 1'b1; e = 24'h101000; end
				1: begin s.rx_empty = 1'b1; e = 24'h100800; end
				2: begin s.tx_full = 1'b1; e = 24'h000028; end
				3: begin s.tx_empty = 1'b1; e = 24'h000018; end
				4: begin f.fbit_en = 1'b1; f.fbit_err = 1'b1; e = 24'h000100; end
				default: begin
					f.resync_done = 1'b1;
					f.align_changed = seed[8];
					e = {8'h00, seed[8], 15'h0000};
				end
			endcase
			pulse(f, s);
			settle();
			look(8'h20, 8'h10, e[23:16]);
			look(8'h22, 8'h99, e[15:8]);
			look(8'h31, 8'h38, e[7:0]);
		end
		// a zero mask bit holds the copy, a one reloads it from the latch
		s = '0;
		s.rx_full = 1'b1;
		pulse('0, s);
		settle();
		bus(1'b1, 8'h22, 8'h10);
		bus(1'b1, 8'h22, 8'h00);
		bus(1'b0, 8'h22, 8'h00);
		check(o_rdata & 8'h10, 8'h10);
		bus(1'b1, 8'h22, 8'h10);
		bus(1'b0, 8'h22, 8'h00);
		check(o_rdata & 8'h10, 8'h00);
		// severe framing needs two errors among six framing bits
		clr_all();
		repeat (6) fbit(1'b0);
		fbit(1'b1);
		settle();
		look(8'h22, 8'h05, 8'h01);
		fbit(1'b1);
		settle();
		look(8'h22, 8'h05, 8'h05);
		// jitter fill one short of and at the trip point
		i_jit_deep = rnd() & 32'h1;
		i_jit_fill = (i_jit_deep ? 8'd128 : 8'd32) - 8'd5;
		settle();
		clr_all();
		look(8'h31, 8'h04, 8'h00);
		i_jit_fill = i_jit_fill + 8'd1;
		settle();
		look(8'h31, 8'h04, 8'h04);
		// transmit stream: fifteen spaces pass, the sixteenth violates
		for (int i = 0; i < 16; i++) begin
			@(posedge i_rx_clk);
			#2;
			i_tx_bit_en = 1'b1;
			@(posedge i_rx_clk);
			#2;
			i_tx_bit_en = 1'b0;
			if (i == 14) begin
				settle();
				look(8'h31, 8'h01, 8'h00);
			end
		end
		settle();
		look(8'h31, 8'h01, 8'h01);
		// every level code reaches the level field
		for (int c = 0; c < 4; c++) begin
			@(posedge i_rx_clk);
			#2;
			i_rx_level = c[1:0];
			settle();
			clr_all();
			look(8'h31, 8'hc0, {c[1:0], 6'h00});
		end
		// twelfth bit yellow: two ones in a row set, two zeros in a row clear
		f = '0;
		f.f12_en = 1'b1;
		i_yellow_mode_select = 1'b1;
		for (int c = 0; c < 4; c++) begin
			f.f12 = c < 2;
			pulse(f, '0);
			settle();
			clr_all();
			look(8'h20, 8'h04, {5'h00, c == 1 || c == 2, 2'h0});
		end
		// data link yellow: 15 matches hold, 16 set, 15 hold, 14 clear
		i_esf_mode = 1'b1;
		f = '0;
		f.fdl_en = 1'b1;
		for (int c = 0; c < 18; c++) begin
			f.fdl_match = c < 16;
			pulse(f, '0);
			if (c >= 14) begin
				settle();
				clr_all();
				look(8'h20, 8'h04, {5'h00, c == 15 || c == 16, 2'h0});
			end
		end
		// bit two yellow: 254 zeros of 256 set, 253 clear
		i_esf_mode = 1'b0;
		i_yellow_mode_select = 1'b0;
		f = '0;
		f.bit2_en = 1'b1;
		for (int i = 0; i < 512; i++) begin
			f.bit2 = (i % 256) < (2 + i / 256);
			pulse(f, '0);
			if (i % 256 == 255) begin
				settle();
				clr_all();
				look(8'h20, 8'h04, {5'h00, i < 256, 2'h0});
			end
		end
		// stopped transmit clock, lost sync and an all-ones line
		check({7'h00, o_irq_out_first}, 8'h00);
		tx_clock_in_run = 1'b0;
		@(posedge i_rx_clk);
		#2;
		i_framer.sync_ok = 1'b0;
		repeat (70) @(posedge i_rx_clk);
		repeat (8) @(posedge i_clk);
		#1;
		check({7'h00, o_tx_clock_alarm}, 8'h01);
		check({7'h00, o_irq_out_first}, 8'h01);
		look(8'h20, 8'h29, 8'h29);
		i_clock_loss_output_enable = 1'b0;
		i_irq_mask_first = 8'h00;
		repeat (4) @(posedge i_clk);
		#1;
		check({7'h00, o_tx_clock_alarm}, 8'h00);
		check({7'h00, o_irq_out_first}, 8'h00);
		stop_test();
	end
endmodule
